//--- hdl/bbwsp_pkg.sv
// Constants and types shared by the two-beat burst byte-write port
package bbwsp_pkg;

    // ------------------------------------------------------------------
    // Organisation and burst
    // ------------------------------------------------------------------
    localparam int BBWSP_LANE_W = 9;
    localparam int BBWSP_BURST_LEN = 2;
    localparam int BBWSP_BEAT_BITS = 1;
    localparam logic BBWSP_BEAT_FIRST = 1'h0;
    localparam logic BBWSP_BEAT_SECOND = 1'h1;

    // ------------------------------------------------------------------
    // Clock phases and reset values
    // ------------------------------------------------------------------
    localparam logic BBWSP_PH_TRUE = 1'h0;
    localparam logic BBWSP_PH_COMP = 1'h1;
    localparam logic BBWSP_PHASE_RST = 1'h0;
    localparam logic BBWSP_OE_RST = 1'h0;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        BBWSP_WR_IDLE,
        BBWSP_WR_BEAT1
    } bbwsp_wr_st_t;

    typedef enum logic [1:0] {
        BBWSP_RD_IDLE,
        BBWSP_RD_BEAT0,
        BBWSP_RD_BEAT1
    } bbwsp_rd_st_t;

endpackage : bbwsp_pkg

//--- hdl/bbwsp_port.sv
// Two-beat burst engine with per-beat byte-lane write masking
`timescale 1ns/1ps
module bbwsp_port
    import bbwsp_pkg::*;
#(
    parameter int LANES = 4,
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES*BBWSP_LANE_W-1:0] d,
    input wire logic lane_zero_write_mask_n,
    input wire logic lane_one_write_mask_n,
    input wire logic lane_two_write_mask_n,
    input wire logic lane_three_write_mask_n,
    input wire logic out_clk_held_high,
    output logic k_phase,
    output logic [LANES*BBWSP_LANE_W-1:0] q,
    output logic q_oe,
    output logic q_on_input_clk
);

    // ------------------------------------------------------------------
    // Sizes and elaboration checks
    // ------------------------------------------------------------------
    localparam int DW = LANES * BBWSP_LANE_W;
    localparam int IW = ADDR_W + BBWSP_BEAT_BITS;
    localparam int DEPTH = 2 ** IW;

    generate
        if (LANES != 1 && LANES != 2 && LANES != 4) begin : g_bad_lanes
            $error("LANES must be 1, 2 or 4");
        end
        if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr
            $error("ADDR_W must be 1 to 16");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Package consistency checks
    // ------------------------------------------------------------------
    generate
        if (BBWSP_BEAT_BITS != 1) begin : g_bad_beat_bits
            $error("Beat select must be exactly one address bit");
        end
        if (BBWSP_BURST_LEN != 2 ** BBWSP_BEAT_BITS) begin : g_bad_burst
            $error("Burst length must equal two to the beat bits");
        end
        if (BBWSP_BEAT_FIRST == BBWSP_BEAT_SECOND) begin : g_bad_order
            $error("Beat codes must differ");
        end
    endgenerate

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic phase;
        bbwsp_wr_st_t wr_st;
        logic [ADDR_W-1:0] wr_addr;
        logic [DW-1:0] wb0_d;
        logic [DW-1:0] wb1_d;
        logic [LANES-1:0] wb0_en;
        logic [LANES-1:0] wb1_en;
        logic wb0_pend;
        logic wb1_pend;
        logic rd_a_v;
        logic [ADDR_W-1:0] rd_a_addr;
        bbwsp_rd_st_t rd_st;
        logic [ADDR_W-1:0] rd_b_addr;
        logic [DW-1:0] q;
        logic q_oe;
        logic q_k;
        logic [DEPTH-1:0][DW-1:0] mem;
    } bbwsp_state_t;

    bbwsp_state_t st_r;
    bbwsp_state_t st_nxt;

    logic [3:0] mask_all_n;
    logic [LANES-1:0] lane_en;
    logic true_edge;

    // ------------------------------------------------------------------
    // Lane enables
    // ------------------------------------------------------------------
    assign mask_all_n = {lane_three_write_mask_n, lane_two_write_mask_n,
                         lane_one_write_mask_n, lane_zero_write_mask_n};
    assign lane_en = ~mask_all_n[LANES-1:0];
    assign true_edge = (st_r.phase == BBWSP_PH_TRUE);

    // Merge one beat into a stored word, lane by lane
    function automatic logic [DW-1:0] bbwsp_merge(
        input logic [DW-1:0] old_w,
        input logic [DW-1:0] new_w,
        input logic [LANES-1:0] en
    );
        logic [DW-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (en[i]) begin
                res[i*BBWSP_LANE_W +: BBWSP_LANE_W] =
                    new_w[i*BBWSP_LANE_W +: BBWSP_LANE_W];
            end
        end
        return res;
    endfunction : bbwsp_merge

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [IW-1:0] wi;
        logic [IW-1:0] ri;
        st_nxt = st_r;
        wi = '0;
        ri = '0;
        st_nxt.phase = ~st_r.phase;
        st_nxt.q_oe = BBWSP_OE_RST;
        st_nxt.wb0_pend = 1'b0;
        st_nxt.wb1_pend = 1'b0;

        // Commit registered beats; each has its own mask
        if (st_r.wb0_pend) begin
            wi = {st_r.wr_addr, BBWSP_BEAT_FIRST};
            st_nxt.mem[wi] = bbwsp_merge(st_r.mem[wi], st_r.wb0_d,
                                         st_r.wb0_en);
        end
        if (st_r.wb1_pend) begin
            wi = {st_r.wr_addr, BBWSP_BEAT_SECOND};
            st_nxt.mem[wi] = bbwsp_merge(st_r.mem[wi], st_r.wb1_d,
                                         st_r.wb1_en);
        end

        // Write sequencer
        case (st_r.wr_st)
            BBWSP_WR_IDLE: begin
                if (true_edge && !wr_n) begin
                    st_nxt.wr_addr = addr;
                    st_nxt.wb0_d = d;
                    st_nxt.wb0_en = lane_en;
                    st_nxt.wb0_pend = 1'b1;
                    st_nxt.wr_st = BBWSP_WR_BEAT1;
                end
            end
            BBWSP_WR_BEAT1: begin
                st_nxt.wb1_d = d;
                st_nxt.wb1_en = lane_en;
                st_nxt.wb1_pend = 1'b1;
                st_nxt.wr_st = BBWSP_WR_IDLE;
            end
            default: st_nxt.wr_st = BBWSP_WR_IDLE;
        endcase

        // Read request capture and hand-off to the launch stage
        if (true_edge) begin
            st_nxt.rd_a_v = !rd_n;
            st_nxt.rd_a_addr = rd_n ? st_r.rd_a_addr : addr;
        end

        // Read launch sequencer, independent of the writer
        case (st_r.rd_st)
            BBWSP_RD_IDLE: begin
            end
            BBWSP_RD_BEAT0: begin
                ri = {st_r.rd_b_addr, BBWSP_BEAT_FIRST};
                st_nxt.q = st_r.mem[ri];
                st_nxt.q_oe = 1'b1;
                st_nxt.q_k = out_clk_held_high;
                st_nxt.rd_st = BBWSP_RD_BEAT1;
            end
            BBWSP_RD_BEAT1: begin
                ri = {st_r.rd_b_addr, BBWSP_BEAT_SECOND};
                st_nxt.q = st_r.mem[ri];
                st_nxt.q_oe = 1'b1;
                st_nxt.q_k = out_clk_held_high;
                st_nxt.rd_st = BBWSP_RD_IDLE;
            end
            default: st_nxt.rd_st = BBWSP_RD_IDLE;
        endcase
        if (true_edge && st_r.rd_a_v) begin
            st_nxt.rd_b_addr = st_r.rd_a_addr;
            st_nxt.rd_st = BBWSP_RD_BEAT0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign k_phase = st_r.phase;
    assign q = st_r.q;
    assign q_oe = st_r.q_oe;
    assign q_on_input_clk = st_r.q_k;

endmodule : bbwsp_port

//--- dv/bbwsp_port_asserts.sv
// Port checker for the two-beat burst byte-write port
`timescale 1ns/1ps
module bbwsp_port_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic out_clk_held_high,
    input wire logic k_phase,
    input wire logic q_oe,
    input wire logic q_on_input_clk
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst || !ce);
    property p_kph; 1'h1 |=> k_phase != $past(k_phase); endproperty
    a_kph: assert property (p_kph) else $error("phase stuck");
    property p_rdl; !k_phase && !rd_n |-> ##4 q_oe ##1 q_oe; endproperty
    a_rdl: assert property (p_rdl) else $error("read slot");
    property p_cau; q_oe && !k_phase |-> $past(rd_n, 4) == 1'h0; endproperty
    a_cau: assert property (p_cau) else $error("stray beat");
    property p_par; q_oe && k_phase |-> $past(q_oe); endproperty
    a_par: assert property (p_par) else $error("lone beat");
    property p_ros; $rose(q_oe) |-> !k_phase; endproperty
    a_ros: assert property (p_ros) else $error("beat order");
    property p_nop; !k_phase && rd_n && wr_n |-> ##4 !q_oe; endproperty
    a_nop: assert property (p_nop) else $error("nop drove");
    property p_wrq; !k_phase && rd_n && !wr_n |-> ##4 !q_oe; endproperty
    a_wrq: assert property (p_wrq) else $error("write drove");
    property p_icl;
        q_oe |-> q_on_input_clk == $past(out_clk_held_high);
    endproperty
    a_icl: assert property (p_icl) else $error("clock ref");
endmodule : bbwsp_port_chk
bind bbwsp_port bbwsp_port_chk chk_u (.clk, .sys_rst, .ce, .rd_n, .wr_n,
    .out_clk_held_high, .k_phase, .q_oe, .q_on_input_clk);

//--- dv/bbwsp_ctl.sv
// Memory controller model issuing two-beat bursts
`timescale 1ns/1ps
module bbwsp_ctl (
    input wire logic clk,
    input wire logic k_phase,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] addr,
    output logic [35:0] d,
    output logic [3:0] m_n
);
    initial begin
        rd_n = 1'h1;
        wr_n = 1'h1;
        addr = 8'h0;
        d = 36'h0;
        m_n = 4'hf;
    end
    task automatic req(input logic r, input logic w, input logic [7:0] a,
        input logic [35:0] d0, input logic [3:0] m0,
        input logic [35:0] d1, input logic [3:0] m1);
        @(negedge clk);
        while (k_phase) @(negedge clk);
        rd_n = !r;
        wr_n = !w;
        addr = a;
        d = d0;
        m_n = m0;
        @(negedge clk);
        rd_n = 1'h1;
        wr_n = 1'h1;
        addr = ~a;
        d = d1;
        m_n = m1;
    endtask : req
endmodule : bbwsp_ctl

//--- dv/bbwsp_port_tb_top.sv
// Self-checking bench for the two-beat burst byte-write port
`timescale 1ns/1ps
module bbwsp_port_tb_top;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic hh = 1'h0;
    logic ce = 1'h1;
    logic rd_n, wr_n, k_phase, q_oe, q_ic;
    logic [7:0] addr;
    logic [35:0] d, q;
    logic [3:0] m_n;
    logic [35:0] mem [512];
    int err_count = 0;
    int cmp_count = 0;
    initial forever #4 clk = !clk;
    bbwsp_port dut_u (.clk, .sys_rst, .ce, .rd_n, .wr_n, .addr, .d,
        .lane_zero_write_mask_n(m_n[0]), .lane_one_write_mask_n(m_n[1]),
        .lane_two_write_mask_n(m_n[2]), .lane_three_write_mask_n(m_n[3]),
        .out_clk_held_high(hh), .k_phase, .q, .q_oe, .q_on_input_clk(q_ic));
    bbwsp_ctl ctl_u (.clk, .k_phase, .rd_n, .wr_n, .addr, .d, .m_n);
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic r, input logic w, input logic [7:0] a,
        input logic [35:0] d0, input logic [3:0] m0, input logic [35:0] d1);
        logic [3:0] m1;
        m1 = {m0[2:0], m0[3]};
        for (int l = 0; l < 4 && w; l++) begin
            if (!m0[l]) mem[{a, 1'h0}][l*9+:9] = d0[l*9+:9];
            if (!m1[l]) mem[{a, 1'h1}][l*9+:9] = d1[l*9+:9];
        end
        ctl_u.req(r, w, a, d0, m0, d1, m1);
        if (r) begin
            repeat (3) @(negedge clk);
            chk(36'(q_oe), 36'h1);
            chk(q, mem[{a, 1'h0}]);
            chk(36'(q_ic), 36'(hh));
            @(negedge clk);
            chk(q, mem[{a, 1'h1}]);
        end
    endtask : op
    task automatic t_lanes();
        logic [3:0] pats [6] = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'hf};
        for (int i = 0; i < 6; i++) begin
            op(1'h0, 1'h1, 8'(i * 37), 36'h123456789, 4'h0, 36'hfedcba987);
            op(1'h1, 1'h1, 8'(i * 37), 36'h555555555, pats[i], 36'haaaaaaaaa);
        end
        $display("t_lanes done");
    endtask : t_lanes
    task automatic t_nop();
        op(1'h0, 1'h0, 8'h25, 36'h0f0f0f0f0, 4'h0, 36'h0f0f0f0f0);
        op(1'h1, 1'h0, 8'h25, 36'h0, 4'hf, 36'h0);
        $display("t_nop done");
    endtask : t_nop
    task automatic t_icl();
        hh = 1'h1;
        op(1'h1, 1'h0, 8'h4a, 36'h0, 4'hf, 36'h0);
        hh = 1'h0;
        $display("t_icl done");
    endtask : t_icl
    task automatic t_ce();
        @(negedge clk);
        while (k_phase) @(negedge clk);
        ce = 1'h0;
        repeat (3) @(negedge clk);
        chk(36'(k_phase), 36'h0);
        chk(36'(q_oe), 36'h0);
        ce = 1'h1;
        @(negedge clk);
        chk(36'(k_phase), 36'h1);
        $display("t_ce done");
    endtask : t_ce
    task automatic t_rst();
        @(negedge clk);
        sys_rst = 1'h1;
        @(negedge clk);
        sys_rst = 1'h0;
        foreach (mem[i]) mem[i] = 36'h0;
        chk(36'(k_phase), 36'h0);
        chk(36'(q_oe), 36'h0);
        op(1'h1, 1'h0, 8'h00, 36'h0, 4'hf, 36'h0);
        $display("t_rst done");
    endtask : t_rst
    task automatic end_of_test();
        $display("cmp_count=%0d err_count=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        foreach (mem[i]) mem[i] = 36'h0;
        repeat (6) @(negedge clk);
        sys_rst = 1'h0;
        chk(36'(q_oe), 36'h0);
        t_lanes();
        t_nop();
        t_icl();
        t_ce();
        t_rst();
        end_of_test();
    end
    initial begin
        #20000;
        err_count++;
        end_of_test();
    end
endmodule : bbwsp_port_tb_top
